// ===== hdl/pcc_command_ctrl.sv
// Command register and the gating it applies to target, master and parity
`timescale 1ns/100ps

// Behaviour
// - All-zero command register: only configuration accesses are claimed.
// - Command register is 16 bits and clears to zero on reset.
// - Bit 9: fast back-to-back to other targets only when set.
// - Bit 8 gates the SERR# driver.
// - Address parity errors reach SERR# only with bits 8 and 6 set.
// - Bit 7 stepping control is read-only zero.
// - Bit 6 set: data parity error asserts PERR#.
// - Bit 6 clear: error sets status bit 15, PERR# stays off.
// - PAR is always generated for driven cycles.
// - Bit 5 palette snoop is read-only zero.
// - Bits 4, 2, 1, 0 writable, bit 3 read-only, fixed positions.
// - Bus master bit clear: no transaction is initiated.
// - Memory accesses claimed only while memory space bit is set.
// - Special cycle monitor zero: special cycles are ignored.
module pcc_command_ctrl
   import pcc_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [DATA_W/8-1:0] cfg_be,
   input wire logic [DATA_W-1:0] cfg_wdata,
   output logic [DATA_W-1:0] cfg_rdata,
   output logic cfg_rack,
   input wire logic tgt_req,
   input wire pcc_space_t tgt_space,
   output logic tgt_claim,
   input wire logic mst_req,
   input wire logic mst_same_target,
   output logic mst_grant_req,
   output logic mst_fast_b2b_ok,
   output logic mst_mwi_ok,
   input wire logic addr_perr_det,
   input wire logic data_perr_det,
   output logic perr_n_o,
   output logic perr_oe,
   output logic serr_n_o,
   output logic serr_oe,
   input wire logic [DATA_W-1:0] drv_ad,
   input wire logic [DATA_W/8-1:0] drv_cbe,
   input wire logic drv_en,
   output logic par_o,
   output logic par_oe,
   output logic [PCC_CMD_W-1:0] cmd_value,
   output logic dpe_flag
);

   logic [PCC_CMD_W-1:0] cmd_reg;
   logic [PCC_CMD_W-1:0] cmd_next;
   logic dpe_reg;
   logic perr_reg;
   logic serr_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic rack_reg;
   logic cmd_hit;
   logic dpe_clear;
   logic io_en;
   logic mem_en;
   logic bm_en;
   logic mon_en;
   logic mwi_en;
   logic per_en;
   logic serr_en;
   logic fbb_en;

   initial begin
      if (DATA_W != 32) begin
         $error("pcc_command_ctrl: configuration data must be 32 bits");
      end
   end

   assign cmd_hit = (cfg_addr == PCC_CMD_OFFSET);

   assign io_en = cmd_reg[PCC_IO_SPACE_BIT];
   assign mem_en = cmd_reg[PCC_MEM_SPACE_BIT];
   assign bm_en = cmd_reg[PCC_BUS_MASTER_BIT];
   assign mon_en = cmd_reg[PCC_SPECIAL_MON_BIT];
   assign mwi_en = cmd_reg[PCC_WR_INVAL_BIT];
   assign per_en = cmd_reg[PCC_PAR_RESP_BIT];
   assign serr_en = cmd_reg[PCC_SYS_ERR_BIT];
   assign fbb_en = cmd_reg[PCC_FAST_B2B_BIT];

   // Byte-lane merge; read-only bits never take a written value
   always_comb begin
      cmd_next = cmd_reg;
      if (cfg_wr && cmd_hit) begin
         if (cfg_be[0]) begin
            cmd_next[7:0] = (cfg_wdata[7:0] & PCC_CMD_WR_MASK[7:0])
                          | (cmd_reg[7:0] & ~PCC_CMD_WR_MASK[7:0]);
         end
         if (cfg_be[1]) begin
            cmd_next[15:8] = (cfg_wdata[15:8] & PCC_CMD_WR_MASK[15:8])
                           | (cmd_reg[15:8] & ~PCC_CMD_WR_MASK[15:8]);
         end
      end
   end

   // Reserved bits 15:10 are kept as storage; software should write zero
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cmd_reg <= PCC_CMD_RESET;
      end else begin
         cmd_reg <= cmd_next;
      end
   end

   assign cmd_value = cmd_reg;

   // Status write-one-to-clear on bit 15 of the upper half
   assign dpe_clear = cfg_wr && cmd_hit && cfg_be[3]
                      && cfg_wdata[PCC_STATUS_LSB + PCC_DPE_BIT];

   // A detection in the clearing cycle wins, so no error is lost
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dpe_reg <= PCC_DPE_RESET;
      end else if (addr_perr_det || data_perr_det) begin
         dpe_reg <= 1'b1;
      end else if (dpe_clear) begin
         dpe_reg <= 1'b0;
      end
   end

   assign dpe_flag = dpe_reg;

   // Configuration reads answer one clock after the strobe
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= '0;
      end else if (cfg_rd) begin
         if (cmd_hit) begin
            rdata_reg <= {dpe_reg, 15'h0000, cmd_reg};
         end else begin
            rdata_reg <= '0;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rack_reg <= 1'b0;
      end else begin
         rack_reg <= cfg_rd || cfg_wr;
      end
   end

   assign cfg_rdata = rdata_reg;
   assign cfg_rack = rack_reg;

   // Target decode: configuration is always claimed, whatever the register
   always_comb begin
      tgt_claim = 1'b0;
      if (tgt_req) begin
         case (tgt_space)
            PCC_SPACE_CFG: tgt_claim = 1'b1;
            PCC_SPACE_MEM: tgt_claim = mem_en;
            PCC_SPACE_IO: tgt_claim = io_en;
            PCC_SPACE_SPECIAL: tgt_claim = mon_en;
            default: tgt_claim = 1'b0;
         endcase
      end
   end

   // Master side gating
   assign mst_grant_req = mst_req && bm_en;
   assign mst_fast_b2b_ok = mst_same_target || fbb_en;
   assign mst_mwi_ok = mwi_en;

   // PERR# only with parity response enabled
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         perr_reg <= 1'b0;
      end else begin
         perr_reg <= data_perr_det && per_en;
      end
   end

   // SERR# needs both enables; driver stays off otherwise
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         serr_reg <= 1'b0;
      end else begin
         serr_reg <= addr_perr_det && per_en && serr_en;
      end
   end

   // Open-drain style: drive low while enabled, release otherwise
   assign perr_n_o = 1'b0;
   assign perr_oe = perr_reg;
   assign serr_n_o = 1'b0;
   assign serr_oe = serr_reg;

   pcc_parity_gen #(
      .DATA_W(DATA_W),
      .CBE_W(DATA_W / 8)
   ) u_parity (
      .clock(clock),
      .arst_n(arst_n),
      .drv_ad(drv_ad),
      .drv_cbe(drv_cbe),
      .drv_en(drv_en),
      .par_o(par_o),
      .par_oe(par_oe)
   );

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   logic seen_edge_reg;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         seen_edge_reg <= 1'b0;
      end else begin
         seen_edge_reg <= 1'b1;
      end
   end

   sequence data_err_resp_s;
      data_perr_det && per_en;
   endsequence

   sequence data_err_quiet_s;
      data_perr_det && !per_en;
   endsequence

   sequence addr_err_report_s;
      addr_perr_det && per_en && serr_en;
   endsequence

   zero_cmd_isolate_a: assert property (
      (cmd_reg == 16'h0000) && tgt_req
      |-> tgt_claim == (tgt_space == PCC_SPACE_CFG))
      else $error("Access claimed while command register is zero");

   reset_clear_a: assert property (
      !seen_edge_reg |-> (cmd_reg == PCC_CMD_RESET) && !dpe_reg)
      else $error("Command register not zero after reset");

   fast_b2b_a: assert property (
      !mst_same_target && mst_fast_b2b_ok |-> fbb_en)
      else $error("Fast back-to-back to other target while disabled");

   serr_gate_a: assert property (
      serr_oe |-> $past(serr_en) && $past(addr_perr_det))
      else $error("SERR# driven without its enable");

   addr_err_report_a: assert property (
      addr_err_report_s |=> serr_oe ##1 !serr_oe || addr_perr_det)
      else $error("Address parity error not reported on SERR#");

   ro_bits_zero_a: assert property (
      !cmd_value[PCC_STEPPING_BIT] && !cmd_value[PCC_PALETTE_BIT]
      && !cmd_value[PCC_SPECIAL_MON_BIT])
      else $error("Read-only command bit became set");

   perr_resp_a: assert property (
      data_err_resp_s |=> perr_oe && dpe_reg)
      else $error("PERR# missing with parity response enabled");

   dpe_quiet_a: assert property (
      data_err_quiet_s |=> !perr_oe && dpe_reg)
      else $error("Parity error handling wrong with response disabled");

   writable_bits_a: assert property (
      cfg_wr && cmd_hit && cfg_be[0]
      |=> cmd_reg[2:0] == $past(cfg_wdata[2:0])
          && cmd_reg[PCC_WR_INVAL_BIT] == $past(cfg_wdata[PCC_WR_INVAL_BIT]))
      else $error("Writable command bit not updated");

   bus_master_a: assert property (
      mst_grant_req |-> bm_en && mst_req)
      else $error("Master request passed with bus master disabled");

   mem_claim_a: assert property (
      tgt_req && tgt_space == PCC_SPACE_MEM |-> tgt_claim == mem_en)
      else $error("Memory claim disagrees with memory space bit");

   special_ignore_a: assert property (
      tgt_space == PCC_SPACE_SPECIAL |-> !tgt_claim)
      else $error("Special cycle claimed");

   io_claim_a: assert property (
      tgt_req && tgt_space == PCC_SPACE_IO |-> tgt_claim == io_en)
      else $error("I/O claim disagrees with I/O space bit");

endmodule

// ===== shared/pcc_pkg.sv
// Constants and types shared by the command register control block
package pcc_pkg;

   // Configuration space layout
   localparam logic [7:0] PCC_CMD_OFFSET = 8'h04;
   localparam int PCC_CMD_W = 16;
   localparam int PCC_STATUS_LSB = 16;

   // Command register reset value and writable bits
   localparam logic [15:0] PCC_CMD_RESET = 16'h0000;
   localparam logic [15:0] PCC_CMD_WR_MASK = 16'hff57;

   // Command register field positions
   localparam int PCC_IO_SPACE_BIT = 0;
   localparam int PCC_MEM_SPACE_BIT = 1;
   localparam int PCC_BUS_MASTER_BIT = 2;
   localparam int PCC_SPECIAL_MON_BIT = 3;
   localparam int PCC_WR_INVAL_BIT = 4;
   localparam int PCC_PALETTE_BIT = 5;
   localparam int PCC_PAR_RESP_BIT = 6;
   localparam int PCC_STEPPING_BIT = 7;
   localparam int PCC_SYS_ERR_BIT = 8;
   localparam int PCC_FAST_B2B_BIT = 9;

   // Status half of the dword: detected parity error position
   localparam int PCC_DPE_BIT = 15;
   localparam logic PCC_DPE_RESET = 1'b0;

   // Cycles from a detected error to the PERR# or SERR# driver
   localparam int PCC_ERR_LATENCY = 1;

   // Address space of a target access offered for claiming
   typedef enum logic [3:0] {
      PCC_SPACE_CFG = 4'h1,
      PCC_SPACE_MEM = 4'h2,
      PCC_SPACE_IO = 4'h4,
      PCC_SPACE_SPECIAL = 4'h8
   } pcc_space_t;

endpackage

// ===== hdl/pcc_parity_gen.sv
// Even parity generator for the driven address/data and command/enables
`timescale 1ns/100ps
module pcc_parity_gen
   import pcc_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int CBE_W = 4
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [DATA_W-1:0] drv_ad,
   input wire logic [CBE_W-1:0] drv_cbe,
   input wire logic drv_en,
   output logic par_o,
   output logic par_oe
);

   logic par_reg;
   logic par_oe_reg;

   initial begin
      if (DATA_W < 8 || DATA_W % 8 != 0 || CBE_W != DATA_W / 8) begin
         $error("pcc_parity_gen: unsupported bus widths");
      end
   end

   // Parity lags its data by one clock; generated whatever the checking mode
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         par_reg <= 1'b0;
      end else begin
         par_reg <= ^{drv_ad, drv_cbe};
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         par_oe_reg <= 1'b0;
      end else begin
         par_oe_reg <= drv_en;
      end
   end

   assign par_o = par_reg;
   assign par_oe = par_oe_reg;

   par_even_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      drv_en |=> par_oe && (par_o == ^{$past(drv_ad), $past(drv_cbe)}))
      else $error("PAR does not match driven cycle");

endmodule

// ===== tb/pcc_host_model.sv
// Host bridge model issuing configuration reads and writes
`timescale 1ns/100ps
module pcc_host_model
   import pcc_pkg::*;
#(
   // Every target on the bus handles fast back-to-back
   parameter bit ALL_FAST_B2B = 1'b1
) (
   input wire logic clock,
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rack
);
   logic last_ack;
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
      last_ack = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      @(negedge clock);
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = {d[31:16], 6'h00, d[9] & ALL_FAST_B2B, d[8:0]};
      cfg_wr = 1'b1;
      @(negedge clock);
      cfg_wr = 1'b0;
      last_ack = cfg_rack;
      // Idle bus shows garbage, not the last value
      cfg_wdata = ~cfg_wdata;
      cfg_addr = ~cfg_addr;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge clock);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(negedge clock);
      cfg_rd = 1'b0;
      last_ack = cfg_rack;
      d = cfg_rdata;
      cfg_addr = ~cfg_addr;
   endtask
endmodule

// ===== tb/pci_command_register_control_tb_top.sv
// Self-checking bench for the command register control block
`timescale 1ns/100ps
module pci_command_register_control_tb_top
   import pcc_pkg::*;
;
   logic clock, arst_n, cfg_wr, cfg_rd, cfg_rack, tgt_req, tgt_claim;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be, drv_cbe;
   logic [31:0] cfg_wdata, cfg_rdata, drv_ad, rd_d;
   pcc_space_t tgt_space;
   logic mst_req, mst_same, grant, fb2b, mwi, a_det, d_det;
   logic perr_n, perr_oe, serr_n, serr_oe, drv_en, par_o, par_oe, detected_parity_error;
   logic [15:0] cmd;
   int n_fail = 0;
   int num_checks = 0;
   logic [31:0] ads [3] = '{32'h0000_0001, 32'hdead_beef, 32'h8000_0000};
   logic [3:0] cbes [3] = '{4'h0, 4'h5, 4'h1};

   pcc_host_model host_u (.clock(clock), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rack(cfg_rack));
   pcc_command_ctrl dut_u (.clock(clock), .arst_n(arst_n),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rack(cfg_rack), .tgt_req(tgt_req), .tgt_space(tgt_space),
      .tgt_claim(tgt_claim), .mst_req(mst_req),
      .mst_same_target(mst_same), .mst_grant_req(grant),
      .mst_fast_b2b_ok(fb2b), .mst_mwi_ok(mwi), .addr_perr_det(a_det),
      .data_perr_det(d_det), .perr_n_o(perr_n), .perr_oe(perr_oe),
      .serr_n_o(serr_n), .serr_oe(serr_oe), .drv_ad(drv_ad),
      .drv_cbe(drv_cbe), .drv_en(drv_en), .par_o(par_o), .par_oe(par_oe),
      .cmd_value(cmd), .dpe_flag(detected_parity_error));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      host_u.rd(a, rd_d);
      chk("cfg_rdata", e, rd_d);
      chk("cfg_rack", 32'h1, {31'h0, host_u.last_ack});
   endtask

   // Claim decision for each space: cfg, mem, io, special
   task automatic claims(input logic [3:0] e);
      pcc_space_t sp [4] = '{PCC_SPACE_CFG, PCC_SPACE_MEM, PCC_SPACE_IO,
                             PCC_SPACE_SPECIAL};
      for (int i = 0; i < 4; i++) begin
         @(negedge clock);
         tgt_req = 1'b1;
         tgt_space = sp[i];
         #1;
         chk("tgt_claim", {31'h0, e[i]}, {31'h0, tgt_claim});
      end
      @(negedge clock);
      tgt_req = 1'b0;
   endtask

   task automatic err(input logic a, input logic d, input logic ep,
                      input logic es);
      @(negedge clock);
      a_det = a;
      d_det = d;
      @(negedge clock);
      a_det = 1'b0;
      d_det = 1'b0;
      chk("perr_oe", {31'h0, ep}, {31'h0, perr_oe});
      chk("serr_oe", {31'h0, es}, {31'h0, serr_oe});
      chk("dpe_flag", 32'h1, {31'h0, detected_parity_error});
      @(negedge clock);
      chk("oe pair", 32'h0, {30'h0, perr_oe, serr_oe});
      host_u.wr(8'h04, 4'h8, 32'h8000_0000);
   endtask

   initial begin
      #(25 * 3000);
      n_fail++;
      wrap_up();
   end

   initial begin
      arst_n = 1'b0;
      {tgt_req, mst_req, mst_same, a_det, d_det, drv_en} = 6'h00;
      tgt_space = PCC_SPACE_CFG;
      drv_ad = 32'h0;
      drv_cbe = 4'h0;
      repeat (12) @(posedge clock);
      @(negedge clock);
      arst_n = 1'b1;
      chk("cmd_value", 32'h0, {16'h0, cmd});
      rdc(8'h04, 32'h0);
      claims(4'b0001);
      mst_req = 1'b1;
      #1 chk("grant", 32'h0, {31'h0, grant});
      host_u.wr(8'h04, 4'h3, 32'h0000_ffff);
      chk("cfg_rack", 32'h1, {31'h0, host_u.last_ack});
      rdc(8'h04, 32'h0000_0357);
      claims(4'b0111);
      chk("grant", 32'h1, {31'h0, grant});
      chk("fb2b", 32'h1, {31'h0, fb2b});
      chk("mwi", 32'h1, {31'h0, mwi});
      host_u.wr(8'h04, 4'h1, 32'h0000_0000);
      chk("cmd_value", 32'h0300, {16'h0, cmd});
      chk("mwi", 32'h0, {31'h0, mwi});
      claims(4'b0001);
      host_u.wr(8'h04, 4'h2, 32'h0000_0000);
      chk("fb2b", 32'h0, {31'h0, fb2b});
      mst_same = 1'b1;
      #1 chk("fb2b", 32'h1, {31'h0, fb2b});
      host_u.wr(8'h08, 4'h3, 32'h0000_ffff);
      chk("cmd_value", 32'h0, {16'h0, cmd});
      rdc(8'h08, 32'h0);
      err(1'b0, 1'b1, 1'b0, 1'b0);
      host_u.wr(8'h04, 4'h3, 32'h0000_0040);
      err(1'b0, 1'b1, 1'b1, 1'b0);
      err(1'b1, 1'b0, 1'b0, 1'b0);
      host_u.wr(8'h04, 4'h3, 32'h0000_0100);
      err(1'b1, 1'b0, 1'b0, 1'b0);
      host_u.wr(8'h04, 4'h3, 32'h0000_0140);
      err(1'b1, 1'b0, 1'b0, 1'b1);
      chk("drive levels", 32'h0, {30'h0, perr_n, serr_n});
      rdc(8'h04, 32'h0000_0140);
      // Reset in mid-run must clear a register that holds set bits
      @(negedge clock);
      arst_n = 1'b0;
      @(negedge clock);
      chk("cmd_value", 32'h0, {16'h0, cmd});
      chk("cfg_rack", 32'h0, {31'h0, cfg_rack});
      arst_n = 1'b1;
      rdc(8'h04, 32'h0);
      for (int i = 0; i < 3; i++) begin
         @(negedge clock);
         drv_en = 1'b1;
         drv_ad = ads[i];
         drv_cbe = cbes[i];
         @(negedge clock);
         drv_en = 1'b0;
         chk("par_o", {31'h0, ^{ads[i], cbes[i]}}, {31'h0, par_o});
         chk("par_oe", 32'h1, {31'h0, par_oe});
      end
      @(negedge clock);
      chk("par_oe", 32'h0, {31'h0, par_oe});
      wrap_up();
   end
endmodule
